// >>> sim/revs_assertions.sv
// checker for the rail register bank, sees only the top ports
// assumes the internal reset copy lags rst_n by two edges
module revs_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire revs_pkg::revs_req_t req,
  input wire logic power_on_request_pin,
  input wire logic [2:0] seq_step,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic wr_reject,
  input wire revs_pkg::revs_rails_t rails,
  input wire revs_pkg::revs_uv_t uv_threshold,
  input wire logic [7:0] rail_on_off_control,
  input wire logic [7:0] undervoltage_lockout_level,
  input wire logic [7:0] sequencer_step_assign_1,
  input wire logic [7:0] sequencer_step_assign_2
);
  import revs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic locked;
  // write without the password step to a mapped offset
  assign locked = req.wr && !req.unlocked && req.addr inside {8'h16, 8'h18, 8'h19, 8'h1A};
  property p_rsv_on; rail_on_off_control[7] == 1'b0; endproperty
  a_rsv_on: assert property (p_rsv_on) else $error("on/off bit 7 set");
  property p_rsv_uv; undervoltage_lockout_level[7:3] == 5'h00; endproperty
  a_rsv_uv: assert property (p_rsv_uv) else $error("lockout reserved set");
  property p_rsv_step;
    sequencer_step_assign_1[7] == 1'b0 && sequencer_step_assign_1[3] == 1'b0;
  endproperty
  a_rsv_step: assert property (p_rsv_step) else $error("step reserved set");
  property p_hold;
    locked |=> $stable({rail_on_off_control, undervoltage_lockout_level,
      sequencer_step_assign_1, sequencer_step_assign_2});
  endproperty
  a_hold: assert property (p_hold) else $error("locked write stored");
  property p_rej; locked |=> wr_reject; endproperty
  a_rej: assert property (p_rej) else $error("no reject pulse");
  property p_wr;
    req.wr && req.unlocked && req.addr == 8'h16 |=>
      rail_on_off_control == ($past(req.wdata) & 8'h7F);
  endproperty
  a_wr: assert property (p_wr) else $error("on/off write wrong");
  property p_lin;
    {rails.linreg_one, rails.linreg_two} == $past(rail_on_off_control[1:0]);
  endproperty
  a_lin: assert property (p_lin) else $error("linreg rails wrong");
  property p_gate;
    (!power_on_request_pin) [*4] |-> {rails.switch_one, rails.switch_two,
      rails.buck_one, rails.buck_two, rails.buck_three} == 5'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("rail on with pin low");
  property p_uv; uv_threshold == $past(undervoltage_lockout_level[1:0]); endproperty
  a_uv: assert property (p_uv) else $error("threshold decode wrong");
  c_lock: cover property (locked);
  c_read: cover property (rdata_valid);
  c_pin: cover property (power_on_request_pin && rails.switch_one);
endmodule : revs_assertions

bind revs_top revs_assertions u_chk (.*);

// >>> sim/revs_host_model.sv
// host model: one byte request per call on the register port
// assumes the bank samples req on the rising clk edge
module revs_host (
  input wire logic clk,
  output revs_pkg::revs_req_t req
);
  import revs_pkg::*;
  initial req = '0;
  // request held for one edge, then released with scrambled fields
  task automatic xfer(input logic w, u, input logic [7:0] a, d);
    @(posedge clk);
    req <= '{w, !w, u, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask : xfer
endmodule : revs_host

// >>> sim/revs_top_tb_top.sv
// self-checking bench for the rail register bank
// assumes the host model drives req, the bench drives pin and step
module revs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import revs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pin = 1'b0, rdata_valid;
  logic [2:0] step = 3'h0;
  logic [7:0] rdata, q[$], dat[4];
  logic [7:0] ofs[4] = '{8'h16, 8'h18, 8'h19, 8'h1A};
  logic [7:0] msk[4] = '{8'h7F, 8'h07, 8'h77, 8'h7F};
  logic [31:0] lf = 32'd66562;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  revs_req_t req;
  revs_rails_t rails;
  revs_uv_t uv;
  // 20 MHz clock
  always #25 clk = ~clk;
  revs_host host (.clk(clk), .req(req));
  revs_top uut (.clk(clk), .rst_n(rst_n), .req(req), .power_on_request_pin(pin),
    .seq_step(step), .rdata(rdata), .rdata_valid(rdata_valid), .wr_reject(),
    .rails(rails), .uv_threshold(uv), .rail_on_off_control(),
    .undervoltage_lockout_level(), .sequencer_step_assign_1(),
    .sequencer_step_assign_2());
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nx
  task automatic check(string n, logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic rd(input logic [7:0] a, e);
    q.push_back(e);
    host.xfer(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic rail(string n, logic [6:0] e);
    repeat (5) @(posedge clk);
    check(n, {1'b0, rails}, {1'b0, e});
  endtask : rail
  // read results matched against the oldest note; hang guard
  always @(posedge clk) begin
    if (rdata_valid === 1'b1)
      check("rdata", rdata, q.pop_front());
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], i == 1 ? 8'h03 : 8'h00);
    $display("test reset_values done");
    // random unlocked writes, read back through the masks
    foreach (ofs[i]) begin
      lf = nx(lf);
      dat[i] = lf[7:0] & msk[i];
      host.xfer(1'b1, 1'b1, ofs[i], lf[7:0]);
      rd(ofs[i], dat[i]);
    end
    // locked and unmapped writes change nothing
    foreach (ofs[i]) begin
      host.xfer(1'b1, 1'b0, ofs[i], ~dat[i]);
      rd(ofs[i], dat[i]);
    end
    host.xfer(1'b1, 1'b1, 8'h17, 8'hFF);
    rd(8'h16, dat[0]);
    $display("test write_protect done");
    for (int v = 0; v < 4; v++) begin
      host.xfer(1'b1, 1'b1, 8'h18, 8'(v));
      repeat (3) @(posedge clk);
      check("uv", 8'(uv), 8'(v));
    end
    host.xfer(1'b1, 1'b1, 8'h19, 8'h00);
    host.xfer(1'b1, 1'b1, 8'h16, 8'hFF);
    rail("pin_low", 7'h03);
    pin <= 1'b1;
    rail("pin_high", 7'h7F);
    host.xfer(1'b1, 1'b1, 8'h16, 8'h18);
    host.xfer(1'b1, 1'b1, 8'h19, 8'h32);
    for (int s = 0; s < 4; s++) begin
      step <= 3'(s);
      rail("step", s == 3 ? 7'h18 : s == 2 ? 7'h08 : 7'h00);
    end
    host.xfer(1'b1, 1'b1, 8'h19, 8'h00);
    rail("no_step", 7'h18);
    $display("test rails done");
    give_verdict();
  end
endmodule : revs_top_tb_top

// >>> verilog/revs_pkg.sv
// package for the rail enable, lockout and sequencer register bank
// assumes a byte-wide register port fed by an upstream serial slave
package revs_pkg;
  localparam logic [7:0] OFS_RAIL_ON_OFF = 8'h16;
  localparam logic [7:0] OFS_UV_LEVEL = 8'h18;
  localparam logic [7:0] OFS_STEP_1 = 8'h19;
  localparam logic [7:0] OFS_STEP_2 = 8'h1A;
  localparam logic [7:0] RST_RAIL_ON_OFF = 8'h00;
  localparam logic [7:0] RST_UV_LEVEL = 8'h03;
  localparam logic [7:0] RST_STEP_1 = 8'h00;
  localparam logic [7:0] RST_STEP_2 = 8'h00;
  localparam logic [7:0] MASK_RAIL_ON_OFF = 8'h7F;
  localparam logic [7:0] MASK_UV_LEVEL = 8'h07;
  localparam logic [7:0] MASK_STEP_1 = 8'h77;
  localparam logic [7:0] MASK_STEP_2 = 8'h7F;
  localparam int BIT_SWITCH_ONE = 6;
  localparam int BIT_SWITCH_TWO = 5;
  localparam int BIT_BUCK_ONE = 4;
  localparam int BIT_BUCK_TWO = 3;
  localparam int BIT_BUCK_THREE = 2;
  localparam int BIT_LINREG_ONE = 1;
  localparam int BIT_LINREG_TWO = 0;
  localparam int NUM_RAILS = 7;
  localparam int STEP_W = 3;
  localparam int POS_BUCK_ONE_STEP = 4;
  localparam int POS_BUCK_TWO_STEP = 0;
  localparam logic [2:0] STEP_NONE = 3'h0;
  localparam logic [1:0] UV_2V73 = 2'h0;
  localparam logic [1:0] UV_2V89 = 2'h1;
  localparam logic [1:0] UV_3V18 = 2'h2;
  localparam logic [1:0] UV_3V30 = 2'h3;

  // host-side register request
  typedef struct packed {
    logic wr;
    logic rd;
    logic unlocked;
    logic [7:0] addr;
    logic [7:0] wdata;
  } revs_req_t;

  // rail enable outputs
  typedef struct packed {
    logic switch_one;
    logic switch_two;
    logic buck_one;
    logic buck_two;
    logic buck_three;
    logic linreg_one;
    logic linreg_two;
  } revs_rails_t;

  typedef enum logic [1:0] {
    UV_SEL_2V73,
    UV_SEL_2V89,
    UV_SEL_3V18,
    UV_SEL_3V30
  } revs_uv_t;
endpackage : revs_pkg

// >>> verilog/revs_regfile.sv
// four-byte storage of the rail control registers with masked writes
// assumes synchronous reset copy and a pre-qualified write strobe
module revs_regfile (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [1:0] wsel,
  input wire logic [7:0] wdata,
  input wire logic [1:0] rsel,
  output logic [7:0] rdata,
  output logic [31:0] all_regs
);
  import revs_pkg::*;

  typedef struct packed {
    logic [3:0][7:0] regs;
    logic [7:0] rdata;
  } revs_rf_state_t;

  localparam logic [3:0][7:0] RST_VALS = {RST_STEP_2, RST_STEP_1, RST_UV_LEVEL,
                                          RST_RAIL_ON_OFF};
  localparam logic [3:0][7:0] WMASKS = {MASK_STEP_2, MASK_STEP_1, MASK_UV_LEVEL,
                                        MASK_RAIL_ON_OFF};

  revs_rf_state_t st_reg;
  revs_rf_state_t st_next;

  // masked write, registered read data
  always_comb begin
    st_next = st_reg;
    if (we) begin
      st_next.regs[wsel] = wdata & WMASKS[wsel];
    end
    st_next.rdata = st_next.regs[rsel];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{regs: RST_VALS, rdata: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign all_regs = st_reg.regs;
endmodule : revs_regfile

// >>> verilog/revs_top.sv
// rail enable, undervoltage lockout and sequencer step register bank
// assumes a serial slave upstream delivers byte requests on clk
// Contract
// - on/off register at 0x16, resets to all zero.
// - writes accepted only through the password-protected path; host must unlock.
// - on/off bit 7 reads zero and ignores writes.
// - bit 6 drives load switch one, only while power pin high.
// - bit 5 drives load switch two, only while power pin high.
// - bit 4 drives buck one while its step field is zero, only while power pin high.
// - bit 3 drives buck two while its step field is zero, only while power pin high.
// - bit 2 drives buck three, only while power pin high.
// - bits 1 and 0 drive linear regulators, no power pin gating.
// - lockout register at 0x18, resets to 0x03.
// - lockout field decodes 2.73, 2.89, 3.18, 3.3 volts.
// - lockout bits 7..3 read zero; bit 2 writable, resets zero.
// - step register one at 0x19; bits 7 and 3 read zero.
// - step code zero removes rail from sequencer control.
// - buck one step field bits 6..4 enables at step N.
// - buck two step field bits 2..0 enables at step N.
// - step register two at 0x1A, protected alike.
module revs_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire revs_pkg::revs_req_t req,
  input wire logic power_on_request_pin,
  input wire logic [revs_pkg::STEP_W-1:0] seq_step,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic wr_reject,
  output revs_pkg::revs_rails_t rails,
  output revs_pkg::revs_uv_t uv_threshold,
  output logic [7:0] rail_on_off_control,
  output logic [7:0] undervoltage_lockout_level,
  output logic [7:0] sequencer_step_assign_1,
  output logic [7:0] sequencer_step_assign_2
);
  import revs_pkg::*;

  typedef struct packed {
    logic [1:0] pin_sync;
    logic rdata_valid;
    logic wr_reject;
    revs_rails_t rails;
    revs_uv_t uv;
  } revs_top_state_t;

  revs_top_state_t st_reg;
  revs_top_state_t st_next;
  logic [1:0] rst_sync_reg; // kept apart: it resets on the raw pin reset
  logic rst_n_int;
  logic hit;
  logic [1:0] sel;
  logic we;
  logic [7:0] rf_rdata;
  logic [31:0] all_regs;
  logic [7:0] reg_on_off;
  logic [7:0] reg_uv;
  logic [7:0] reg_step1;
  logic [7:0] reg_step2;
  logic pin_ok;
  logic [STEP_W-1:0] buck_one_step_field;
  logic [STEP_W-1:0] buck_two_step_field;
  logic [NUM_RAILS-1:0] bit_on;
  logic [NUM_RAILS-1:0] gated;
  logic [NUM_RAILS-1:0] rail_next;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  // address decode
  always_comb begin
    hit = 1'b1;
    sel = 2'h0;
    case (req.addr)
      OFS_RAIL_ON_OFF: sel = 2'h0;
      OFS_UV_LEVEL: sel = 2'h1;
      OFS_STEP_1: sel = 2'h2;
      OFS_STEP_2: sel = 2'h3;
      default: hit = 1'b0;
    endcase
  end

  // write only when unlocked; rejected writes store nothing
  assign we = req.wr && hit && req.unlocked;

  revs_regfile u_regs (
    .clk(clk),
    .rst_n(rst_n_int),
    .we(we),
    .wsel(sel),
    .wdata(req.wdata),
    .rsel(sel),
    .rdata(rf_rdata),
    .all_regs(all_regs)
  );

  // unpack stored registers; reserved bits held zero by write masks
  assign reg_on_off = all_regs[7:0];
  assign reg_uv = all_regs[15:8];
  assign reg_step1 = all_regs[23:16];
  assign reg_step2 = all_regs[31:24];
  assign pin_ok = st_reg.pin_sync[1];
  assign buck_one_step_field = reg_step1[POS_BUCK_ONE_STEP +: STEP_W];
  assign buck_two_step_field = reg_step1[POS_BUCK_TWO_STEP +: STEP_W];

  // per-rail enable bits in on/off register order
  assign bit_on = reg_on_off[NUM_RAILS-1:0];
  // rails gated by power pin: bits 6..2
  localparam logic [NUM_RAILS-1:0] PIN_GATED = 7'h7C;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
      assign gated[gi] = bit_on[gi] && (pin_ok || !PIN_GATED[gi]);
    end
  endgenerate

  // sequencer takes over bucks one and two when their step field is nonzero
  always_comb begin
    rail_next = gated;
    if (buck_one_step_field != STEP_NONE) begin
      rail_next[BIT_BUCK_ONE] = pin_ok && (seq_step >= buck_one_step_field);
    end
    if (buck_two_step_field != STEP_NONE) begin
      rail_next[BIT_BUCK_TWO] = pin_ok && (seq_step >= buck_two_step_field);
    end
  end

  // next state of the top: pin sync, answers, rails, threshold
  always_comb begin
    st_next = st_reg;
    st_next.pin_sync = {st_reg.pin_sync[0], power_on_request_pin};
    st_next.rdata_valid = req.rd && hit;
    st_next.wr_reject = req.wr && hit && !req.unlocked;
    st_next.rails.switch_one = rail_next[BIT_SWITCH_ONE];
    st_next.rails.switch_two = rail_next[BIT_SWITCH_TWO];
    st_next.rails.buck_one = rail_next[BIT_BUCK_ONE];
    st_next.rails.buck_two = rail_next[BIT_BUCK_TWO];
    st_next.rails.buck_three = rail_next[BIT_BUCK_THREE];
    st_next.rails.linreg_one = rail_next[BIT_LINREG_ONE];
    st_next.rails.linreg_two = rail_next[BIT_LINREG_TWO];
    case (reg_uv[1:0])
      UV_2V73: st_next.uv = UV_SEL_2V73;
      UV_2V89: st_next.uv = UV_SEL_2V89;
      UV_3V18: st_next.uv = UV_SEL_3V18;
      UV_3V30: st_next.uv = UV_SEL_3V30;
      default: st_next.uv = UV_SEL_3V30;
    endcase
  end

  // state registers other than reset sync
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_reg.pin_sync <= 2'h0;
      st_reg.rdata_valid <= 1'b0;
      st_reg.wr_reject <= 1'b0;
      st_reg.rails <= '0;
      st_reg.uv <= UV_SEL_3V30;
    end else begin
      st_reg.pin_sync <= st_next.pin_sync;
      st_reg.rdata_valid <= st_next.rdata_valid;
      st_reg.wr_reject <= st_next.wr_reject;
      st_reg.rails <= st_next.rails;
      st_reg.uv <= st_next.uv;
    end
  end

  // outputs straight from flops
  assign rdata = rf_rdata;
  assign rdata_valid = st_reg.rdata_valid;
  assign wr_reject = st_reg.wr_reject;
  assign rails = st_reg.rails;
  assign uv_threshold = st_reg.uv;
  assign rail_on_off_control = reg_on_off;
  assign undervoltage_lockout_level = reg_uv;
  assign sequencer_step_assign_1 = reg_step1;
  assign sequencer_step_assign_2 = reg_step2;
endmodule : revs_top
